// >>> hw/ttc_pkg.sv
// package for the three channel timer counter
package ttc_pkg;
   // ***********************************************
   // widths and encodings
   // ***********************************************
   localparam int CNT_W = 16;
   localparam int NUM_CH = 3;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_RST = 16'h0000;
   // clock source select: 0..4 internal, 5..7 external lines 0..2
   localparam logic [2:0] CLKS_XC0 = 3'h5;
   // gating select: 0 none, 1..3 external line 0..2
   localparam logic [1:0] GATE_NONE = 2'h0;
   // external edge select
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   // generation mode event select: 0 line b, 1..3 external line 0..2
   localparam logic [1:0] EEVT_LINE_B = 2'h0;
   // block mode chaining: 0 clock pin, 1 a-line of other channel
   localparam logic [5:0] BMR_RST = 6'h00;
   localparam int PRESC_W = 8;
   localparam logic [7:0] PRESC_RST = 8'h00;

   // ***********************************************
   // channel mode register
   // ***********************************************
   typedef struct packed {
      logic [2:0] clock_source_select;
      logic clock_invert_bit;
      logic [1:0] gate_select;
      logic wave_mode;
      logic load_b_disable;
      logic load_b_stop;
      logic compare_c_disable;
      logic compare_c_stop;
      logic compare_c_trigger;
      logic trig_from_a;
      logic [1:0] ext_edge;
      logic [1:0] ext_event_select;
      logic external_trigger_enable;
   } ttc_mode_t;

   // one-cycle commands of the channel control register
   typedef struct packed {
      logic clock_enable_command;
      logic clock_disable_command;
      logic software_trigger_bit;
   } ttc_ctrl_t;

   // status of one channel
   typedef struct packed {
      logic counter_overflow_flag;
      logic clock_enabled_status;
      logic clock_running;
   } ttc_stat_t;

   typedef enum logic [1:0] {
      CK_OFF = 2'b01,
      CK_ON = 2'b10
   } ttc_clk_state_t;
endpackage

// >>> hw/ttc_top.sv
// three channel 16-bit timer counter with block level control
`timescale 1ns/1ps
// Contract
// R1: three identical sixteen-bit up counters
// R2: count rising edge of gated chosen clock
// R3: wrap to zero sets overflow flag
// R4: counter value read is live
// R5: trigger zeroes counter at next edge
// R6: block mode chains external lines
// R7: source is five internal or three external
// R8: invert bit counts on opposite edge; here only external sources, internal ticks ignore the bit
// R9: gate line high lets edges pass
// R10: enable/disable commands; disabled ignores start/stop
// R11: second capture or third compare disables
// R12: any trigger starts clock when enabled
// R13: second capture or third compare stops
// R14: mode bit sets line directions
// R15: software trigger bit triggers channel
// R16: block trigger hits all channels
// R17: compare match triggers when enabled
// R18: measurement trigger from line a or b
// R19: generation event triggers when enabled
// R20: each channel drives its interrupt
// R21: external clocks slower than 2.5x master
// R22: external inputs synchronised then edge-detected
module ttc_top #(
   parameter int NCH = ttc_pkg::NUM_CH
) (
   input wire logic clk,
   input wire logic nrst,
   input wire ttc_pkg::ttc_mode_t mode_reg [NCH],
   input wire ttc_pkg::ttc_ctrl_t ctrl_cmd [NCH],
   input wire logic block_sync_trigger,
   input wire logic [5:0] block_mode_register,
   input wire logic [15:0] compare_c_value [NCH],
   input wire logic [NCH-1:0] load_b_event,
   input wire logic [NCH-1:0] ovf_clear,
   input wire logic [NCH-1:0] irq_enable,
   input wire logic [NCH-1:0] ext_clock_pins,
   input wire logic [NCH-1:0] io_line_a_in,
   input wire logic [NCH-1:0] io_line_b_in,
   input wire logic [NCH-1:0] wave_a_level,
   input wire logic [NCH-1:0] wave_b_level,
   output logic [NCH-1:0] io_line_a_out,
   output logic [NCH-1:0] io_line_a_oe,
   output logic [NCH-1:0] io_line_b_out,
   output logic [NCH-1:0] io_line_b_oe,
   output logic [15:0] counter_value_register [NCH],
   output ttc_pkg::ttc_stat_t channel_status_register [NCH],
   output logic [NCH-1:0] irq
);
   import ttc_pkg::*;

   // ***********************************************
   // pin synchronisers and edge detect
   // ***********************************************
   // pins: clock pins, a-lines, b-lines; two flops then a history flop
   localparam int NPIN = 3 * NCH;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_q;
   logic [NPIN-1:0] s2_q;
   logic [NPIN-1:0] s3_q;
   assign pin_raw = {io_line_b_in, io_line_a_in, ext_clock_pins};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_raw; // [R22]
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // only the second and third stages feed logic; first stays private
   logic [NCH-1:0] pin_clk_lvl;
   logic [NCH-1:0] pin_a_lvl;
   logic [NCH-1:0] pin_b_lvl;
   logic [NCH-1:0] pin_clk_old;
   logic [NCH-1:0] pin_a_old;
   logic [NCH-1:0] pin_b_old;
   assign pin_clk_lvl = s2_q[NCH-1:0];
   assign pin_a_lvl = s2_q[2*NCH-1:NCH];
   assign pin_b_lvl = s2_q[3*NCH-1:2*NCH];
   assign pin_clk_old = s3_q[NCH-1:0];
   assign pin_a_old = s3_q[2*NCH-1:NCH];
   assign pin_b_old = s3_q[3*NCH-1:2*NCH];

   // ***********************************************
   // external line routing for chaining
   // ***********************************************
   // line k is its clock pin or the a-line of channel (k+1) mod 3
   logic [2:0] xc_lvl;
   logic [2:0] xc_old;
   genvar gk;
   generate
      for (gk = 0; gk < 3; gk++) begin : g_xc
         localparam int SRC = (gk + 1) % 3;
         assign xc_lvl[gk] = block_mode_register[2*gk] ?
            pin_a_lvl[SRC] : pin_clk_lvl[gk]; // [R6]
         assign xc_old[gk] = block_mode_register[2*gk] ?
            pin_a_old[SRC] : pin_clk_old[gk];
      end
   endgenerate

   // ***********************************************
   // internal prescaled clock enables
   // ***********************************************
   // five rates as one-cycle pulses: /2 /8 /32 /128 and /256
   logic [PRESC_W-1:0] presc_q;
   logic [4:0] int_tick;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         presc_q <= PRESC_RST;
      end else begin
         presc_q <= presc_q + 8'h01;
      end
   end
   assign int_tick[0] = presc_q[0] == 1'b1;
   assign int_tick[1] = presc_q[2:0] == 3'h7;
   assign int_tick[2] = presc_q[4:0] == 5'h1f;
   assign int_tick[3] = presc_q[6:0] == 7'h7f;
   assign int_tick[4] = presc_q == 8'hff;

   // ***********************************************
   // channels
   // ***********************************************
   genvar gc;
   generate
      for (gc = 0; gc < NCH; gc++) begin : g_ch // [R1]
         ttc_mode_t m;
         logic [2:0] sel_x;
         logic sel_lvl;
         logic sel_old;
         logic ext_rise;
         logic ext_fall;
         logic gate_ok;
         logic cnt_edge;
         logic [1:0] gsel;
         logic src_lvl;
         logic src_old;
         logic ev_rise;
         logic ev_fall;
         logic ev_hit;
         logic ext_trig;
         logic match_c;
         logic cmp_trig;
         logic trig;
         logic stop_ev;
         logic dis_ev;
         logic [15:0] cnt_q;
         logic [15:0] cnt_d;
         logic pend_q;
         logic run_q;
         logic ovf_q;
         logic match_seen_q;
         ttc_clk_state_t st_q;
         ttc_clk_state_t st_d;

         assign m = mode_reg[gc];

         // external clock sources 5..7 map to lines 0..2
         assign sel_x = m.clock_source_select - CLKS_XC0;
         assign sel_lvl = xc_lvl[sel_x[1:0]];
         assign sel_old = xc_old[sel_x[1:0]];
         // invert swaps which edge counts
         assign ext_rise = m.clock_invert_bit ?
            (sel_old & ~sel_lvl) : (~sel_old & sel_lvl); // [R8]
         assign gsel = m.gate_select - 2'h1;
         assign gate_ok = (m.gate_select == GATE_NONE) |
            xc_lvl[gsel]; // [R9]
         // internal rates have no inverted edge worth modelling
         assign cnt_edge = gate_ok & ((m.clock_source_select < CLKS_XC0) ?
            int_tick[m.clock_source_select] : ext_rise); // [R2] [R7]

         // external event / trigger source
         assign src_lvl = m.wave_mode ?
            ((m.ext_event_select == EEVT_LINE_B) ? pin_b_lvl[gc] :
             xc_lvl[m.ext_event_select - 2'h1]) :
            (m.trig_from_a ? pin_a_lvl[gc] : pin_b_lvl[gc]); // [R18]
         assign src_old = m.wave_mode ?
            ((m.ext_event_select == EEVT_LINE_B) ? pin_b_old[gc] :
             xc_old[m.ext_event_select - 2'h1]) :
            (m.trig_from_a ? pin_a_old[gc] : pin_b_old[gc]);
         assign ev_rise = ~src_old & src_lvl;
         assign ev_fall = src_old & ~src_lvl;
         assign ev_hit = ((m.ext_edge == EDGE_RISE) & ev_rise) |
            ((m.ext_edge == EDGE_FALL) & ev_fall) |
            ((m.ext_edge == EDGE_BOTH) & (ev_rise | ev_fall));
         assign ext_trig = ev_hit &
            (~m.wave_mode | m.external_trigger_enable); // [R19]

         // compare fires once per counter value, on entering it
         assign match_c = (cnt_q == compare_c_value[gc]);
         assign cmp_trig = match_c & ~match_seen_q & m.compare_c_trigger;
         assign trig = ctrl_cmd[gc].software_trigger_bit |
            block_sync_trigger | ext_trig | cmp_trig; // [R15] [R16] [R17]

         assign stop_ev = m.wave_mode ?
            (match_c & ~match_seen_q & m.compare_c_stop) :
            (load_b_event[gc] & m.load_b_stop); // [R13]
         assign dis_ev = m.wave_mode ?
            (match_c & ~match_seen_q & m.compare_c_disable) :
            (load_b_event[gc] & m.load_b_disable); // [R11]

         // enable state machine
         always_comb begin
            st_d = st_q;
            case (st_q)
               CK_OFF: begin
                  if (ctrl_cmd[gc].clock_enable_command &
                      ~ctrl_cmd[gc].clock_disable_command) begin
                     st_d = CK_ON; // [R10]
                  end
               end
               CK_ON: begin
                  if (ctrl_cmd[gc].clock_disable_command | dis_ev) begin
                     st_d = CK_OFF; // [R10] [R11]
                  end
               end
               default: st_d = CK_OFF;
            endcase
         end

         // wrap counts up; pending reset lands on next counting edge
         always_comb begin
            cnt_d = cnt_q;
            if (cnt_edge & run_q) begin
               cnt_d = pend_q ? CNT_RST : cnt_q + 16'h0001; // [R5] [R2]
            end
         end

         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               st_q <= CK_OFF;
               run_q <= 1'b0;
               pend_q <= 1'b0;
               cnt_q <= CNT_RST;
               ovf_q <= 1'b0;
               match_seen_q <= 1'b0;
            end else begin
               st_q <= st_d;
               // start wins over stop; disable wins over both
               if (st_d != CK_ON) begin
                  run_q <= 1'b0; // [R10]
               end else if (trig) begin
                  run_q <= 1'b1; // [R12]
               end else if (stop_ev) begin
                  run_q <= 1'b0; // [R13]
               end
               if (trig) begin
                  pend_q <= 1'b1;
               end else if (cnt_edge & run_q) begin
                  pend_q <= 1'b0;
               end
               cnt_q <= cnt_d;
               // set beats clear in the same cycle
               if (cnt_edge & run_q & ~pend_q & (cnt_q == CNT_MAX)) begin
                  ovf_q <= 1'b1; // [R3]
               end else if (ovf_clear[gc]) begin
                  ovf_q <= 1'b0;
               end
               match_seen_q <= match_c;
            end
         end

         assign counter_value_register[gc] = cnt_q; // [R4]
         assign channel_status_register[gc].counter_overflow_flag = ovf_q;
         assign channel_status_register[gc].clock_enabled_status =
            (st_q == CK_ON); // [R10]
         assign channel_status_register[gc].clock_running = run_q;
         assign irq[gc] = ovf_q & irq_enable[gc]; // [R20]

         // line directions
         assign io_line_a_oe[gc] = m.wave_mode; // [R14]
         // b stays an input whenever it is the event, trigger or not
         assign io_line_b_oe[gc] = m.wave_mode &
            ~((m.ext_event_select == EEVT_LINE_B) &
              (m.ext_edge != EDGE_NONE)); // [R14]
         assign io_line_a_out[gc] = wave_a_level[gc];
         assign io_line_b_out[gc] = wave_b_level[gc];
      end
   endgenerate
endmodule

// >>> testbench/tb.sv
// self-checking bench for the three channel timer counter
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fails++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb;
   import ttc_pkg::*;
   // ****
   // stimulus and wiring
   // ****
   localparam ttc_ctrl_t C_EN = 3'b100;
   localparam ttc_ctrl_t C_SW = 3'b001;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sync = 1'b0;
   logic [5:0] bmr = 6'h00;
   logic [2:0] ldb = 3'h0, ovc = 3'h0, irqen = 3'h7, ia = 3'h0, ib = 3'h0;
   logic [2:0] lvl = 3'h0;
   logic [2:0] wl = 3'h0;
   wire [2:0] pins, aout, aoe, bout, boe, irq;
   ttc_mode_t mode [3];
   ttc_ctrl_t ctrl [3];
   logic [15:0] cmpv [3];
   logic [15:0] cv [3];
   ttc_stat_t st [3];
   int fails = 0;
   int total_checks = 0;
   int a;
   ttc_top u_ttc_top (.clk(clk), .nrst(nrst), .mode_reg(mode),
      .ctrl_cmd(ctrl), .block_sync_trigger(sync), .block_mode_register(bmr),
      .compare_c_value(cmpv), .load_b_event(ldb), .ovf_clear(ovc),
      .irq_enable(irqen), .ext_clock_pins(pins), .io_line_a_in(ia),
      .io_line_b_in(ib), .wave_a_level(wl), .wave_b_level(wl),
      .io_line_a_out(aout), .io_line_a_oe(aoe), .io_line_b_out(bout),
      .io_line_b_oe(boe), .counter_value_register(cv),
      .channel_status_register(st), .irq(irq));
   ttc_ext_model u_ttc_ext_model (.pins(pins), .lvl(lvl));
   initial begin
      forever #4 clk = ~clk;
   end
   // one-cycle command, cleared at the next falling edge, where the task returns
   task automatic cmd(input int ch, input ttc_ctrl_t c);
      @(negedge clk);
      ctrl[ch] = c;
      @(negedge clk);
      ctrl[ch] = '0;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      results();
   end
   initial begin
      foreach (mode[i]) begin
         mode[i] = '0;
         ctrl[i] = '0;
         cmpv[i] = 16'h0005;
      end
      tick(20);
      nrst = 1'b1;
      for (int i = 0; i < 3; i++) begin
         `CHK("counter", 16'h0000, cv[i])
         `CHK("status", 3'h0, st[i])
      end
      cmd(0, C_SW);
      `CHK("run off", 1'b0, st[0].clock_running)
      cmd(0, 3'b110);
      `CHK("both cmds", 1'b0, st[0].clock_enabled_status)
      cmd(0, C_EN);
      `CHK("enabled", 1'b1, st[0].clock_enabled_status)
      cmd(0, C_SW);
      `CHK("run on", 1'b1, st[0].clock_running)
      tick(10);
      a = cv[0];
      tick(20);
      `CHK("live count", 16'(a + 10), cv[0])
      $display("test count done");
      mode[0].wave_mode = 1'b1;
      mode[0].compare_c_stop = 1'b1;
      mode[0].compare_c_disable = 1'b1;
      cmd(0, C_SW);
      tick(40);
      `CHK("stop at match", 16'h0005, cv[0])
      `CHK("stopped", 1'b0, st[0].clock_running)
      `CHK("disabled", 1'b0, st[0].clock_enabled_status)
      mode[0].compare_c_stop = 1'b0;
      mode[0].compare_c_disable = 1'b0;
      mode[0].compare_c_trigger = 1'b1;
      cmd(0, C_EN);
      cmd(0, C_SW);
      a = 0;
      repeat (60) begin
         @(negedge clk);
         if (cv[0] > a) a = cv[0];
      end
      `CHK("compare wrap", 5, a)
      $display("test compare done");
      mode[0] = '0;
      cmd(1, C_EN);
      cmd(2, C_EN);
      @(negedge clk);
      sync = 1'b1;
      @(negedge clk);
      sync = 1'b0;
      for (int i = 0; i < 3; i++)
         `CHK("sync run", 1'b1, st[i].clock_running)
      mode[1].clock_source_select = CLKS_XC0 + 3'h1;
      mode[1].gate_select = 2'h1;
      for (int i = 0; i < 4; i++) begin
         mode[1].clock_invert_bit = i[0];
         lvl[0] = i[1];
         tick(5);
         a = cv[1];
         u_ttc_ext_model.burst(8);
         tick(6);
         // the sync left a trigger pending: its first edge only zeroes
         a = a + 8 * i[1] - (i == 2);
         `CHK("ext count", 16'(a), cv[1])
      end
      bmr = 6'h04;
      tick(5);
      a = cv[1];
      u_ttc_ext_model.burst(8);
      tick(6);
      `CHK("chained", 16'(a), cv[1])
      // line 1 now follows the a-line of channel 2; counts its falls
      repeat (4) begin
         ia[2] = 1'b1;
         tick(3);
         ia[2] = 1'b0;
         tick(3);
      end
      tick(6);
      `CHK("chained a-line", 16'(a + 4), cv[1])
      $display("test ext clock done");
      for (int k = 0; k < 3; k++) begin
         mode[2].wave_mode = (k < 2);
         mode[2].ext_edge = EDGE_RISE;
         mode[2].external_trigger_enable = (k == 1);
         mode[2].trig_from_a = 1'b1;
         tick(100);
         ia[2] = (k == 2);
         ib[2] = (k < 2);
         tick(3);
         ia[2] = 1'b0;
         ib[2] = 1'b0;
         tick(6);
         `CHK("b line driven", 1'b0, boe[2])
         `CHK("a line driven", k < 2, aoe[2])
         `CHK("ext trigger", k > 0, cv[2] < 16'h0010)
      end
      $display("test ext trigger done");
      mode[1] = '0;
      mode[1].load_b_stop = 1'b1;
      for (int j = 0; j < 2; j++) begin
         @(negedge clk);
         ldb[1] = 1'b1;
         @(negedge clk);
         ldb[1] = 1'b0;
         `CHK("load stop", 1'b0, st[1].clock_running)
         `CHK("load disable", j == 0, st[1].clock_enabled_status)
         mode[1].load_b_disable = 1'b1;
      end
      wl = 3'h5;
      @(negedge clk);
      `CHK("line levels", 6'h2d, {aout, bout})
      `CHK("irq idle", 3'h0, irq)
      $display("test load and levels done");
      results();
   end
endmodule

// >>> testbench/ttc_checker.sv
// port assertions for the timer counter
`timescale 1ns/1ps
module ttc_checker #(
   parameter int NCH = 3
) (
   input wire logic clk,
   input wire logic nrst,
   input wire ttc_pkg::ttc_mode_t mode_reg [NCH],
   input wire ttc_pkg::ttc_ctrl_t ctrl_cmd [NCH],
   input wire logic block_sync_trigger,
   input wire logic [NCH-1:0] io_line_a_oe,
   input wire logic [NCH-1:0] io_line_b_oe,
   input wire logic [15:0] counter_value_register [NCH],
   input wire ttc_pkg::ttc_stat_t channel_status_register [NCH],
   input wire logic [NCH-1:0] irq
);
   import ttc_pkg::*;
   // ****
   // channel 0 views, all-channel vectors
   // ****
   logic [15:0] cv;
   ttc_stat_t s0;
   logic [2:0] en_v;
   logic [2:0] run_v;
   assign cv = counter_value_register[0];
   assign s0 = channel_status_register[0];
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         en_v[i] = channel_status_register[i].clock_enabled_status;
         run_v[i] = channel_status_register[i].clock_running;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   cnt_step_a: assert property ($changed(cv) |->
      cv == $past(cv) + 16'h0001 || cv == 16'h0000)
      else $error("counter moved other than up or to zero");
   irq_source_a: assert property (!s0.counter_overflow_flag &&
      !$past(s0.counter_overflow_flag) |-> !irq[0])
      else $error("irq without overflow");
   dis_cmd_a: assert property (ctrl_cmd[0].clock_disable_command
      |=> !s0.clock_enabled_status)
      else $error("disable command left clock enabled");
   en_cmd_a: assert property (ctrl_cmd[0].clock_enable_command &&
      !ctrl_cmd[0].clock_disable_command |=> s0.clock_enabled_status)
      else $error("enable command not reflected");
   off_start_a: assert property (!s0.clock_enabled_status &&
      !s0.clock_running && !ctrl_cmd[0].clock_enable_command
      |=> !s0.clock_running)
      else $error("clock started while disabled");
   stopped_hold_a: assert property (!s0.clock_running ##1
      !s0.clock_running |-> $stable(cv))
      else $error("counter moved while stopped");
   meas_dir_a: assert property (!mode_reg[0].wave_mode |->
      !io_line_a_oe[0] && !io_line_b_oe[0])
      else $error("line driven in measurement mode");
   wave_dir_a: assert property (mode_reg[0].wave_mode |->
      io_line_a_oe[0])
      else $error("line a not driven in generation mode");
   sync_all_a: assert property (block_sync_trigger &&
      en_v == 3'h7 |=> run_v == 3'h7)
      else $error("block trigger missed a channel");
   b_event_in_a: assert property (mode_reg[2].wave_mode &&
      mode_reg[2].ext_event_select == EEVT_LINE_B &&
      mode_reg[2].ext_edge != EDGE_NONE |-> !io_line_b_oe[2])
      else $error("line b driven while it is the event");
endmodule
bind ttc_top ttc_checker #(.NCH(NCH)) u_ttc_checker (.clk(clk), .nrst(nrst),
   .mode_reg(mode_reg), .ctrl_cmd(ctrl_cmd),
   .block_sync_trigger(block_sync_trigger), .io_line_a_oe(io_line_a_oe),
   .io_line_b_oe(io_line_b_oe),
   .counter_value_register(counter_value_register),
   .channel_status_register(channel_status_register), .irq(irq));

// >>> testbench/ttc_ext_model.sv
// external clock source and static levels on the clock pins
`timescale 1ns/1ps
module ttc_ext_model #(
   parameter int HALF_NS = 24
) (
   output logic [2:0] pins,
   input wire logic [2:0] lvl
);
   // ****
   // pin 1 clocks in frames only, idles low
   // ****
   logic clk1 = 1'b0;
   assign pins = {lvl[2], clk1, lvl[0]};
   // each level three master periods, rate six times lower
   task automatic burst(input int n);
      repeat (n) begin
         #(HALF_NS) clk1 = 1'b1;
         #(HALF_NS) clk1 = 1'b0;
      end
   endtask
endmodule
